// ---- rtl/loop_supervisor.sv ----
// Digital loop supervisor: frequency lock detector, tuning word clamp and
// history, loop state machine, system clock multiplier configuration and
// system clock stability timer, behind an AHB-Lite register slave.
// Assumes samples come from logic on core_clk_i; only the edge-time difference level is synchronised.
//
// Operation
// - Frequency lock uses tub fill/drain accumulator.
// - Fill when |period diff| <= 24-bit threshold.
// - Clamp tuning word to programmed range.
// - Average tuning words; holdover uses average.
// - Switchover: brief holdover, load profile, relock.
// - Freeze frequency lock detector during switchover.
// - Holdover on no reference or request.
// - Valid reference ends holdover, loads profile.
// - User holdover bit blocks automatic recovery.
// - Input divider selects one, two, four, eight.
// - Feedback divider accepts 4 through 255.
// - Prescale chosen by config bits 2:1.
// - System clock lock from edge time difference.
// - Unstable reported until qualification completes.
// - Stable condition starts period timer.
// - Lost condition resets and halts timer.
// - Stable status only after full period.
// - Accumulator saturates at 2048, hysteresis 1024.
// - Separate 8-bit fill and drain steps.
// - Free run or holdover forces unlocked.
`timescale 1ns/100ps
module loop_supervisor #(
	parameter int HIST_W = 8,
	parameter int SYS_LOCK_PS = 1000
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_i,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Digital loop samples and reference status.
	input wire loop_supervisor_pkg::period_sample_t period_i,
	input wire loop_supervisor_pkg::tuning_sample_t tuning_i,
	input wire logic [1:0] ref_valid_i,
	input wire logic ref_sel_i,
	// System clock multiplier edge-time difference, asynchronous level.
	input wire logic [15:0] sys_edge_diff_ps_i,
	// Loop and system clock outputs.
	output logic [29:0] tuning_o,
	output logic freq_lock_o,
	output logic [3:0] loop_state_o,
	output logic profile_load_o,
	output logic [7:0] sys_fb_div_o,
	output logic [3:0] sys_in_div_o,
	output logic [1:0] sys_pdiv_o,
	output logic sys_dbl_o,
	output logic sys_stable_o
);

	////////////////////////////////////////////////////////////////////////
	// Register file.

	logic [7:0] fb_div_ff;
	logic [7:0] in_cfg_ff;
	logic [23:0] nom_per_ff;
	logic [7:0] mode_ff;
	logic [7:0] fill_ff;
	logic [7:0] drain_ff;
	logic [23:0] freq_thr_ff;
	logic [29:0] clamp_lo_ff;
	logic [29:0] clamp_hi_ff;
	logic [HIST_W-1:0] hist_len_ff;
	logic [23:0] stab_per_ff;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [11:0] idx_ff;
	logic [31:0] rdata;

	// Bus address phase decode; byte address is four times the index.
	wire addr_take = hsel_i && hready_i && htrans_i[1];
	wire [11:0] addr_idx = haddr_i[13:2];
	wire wr_fb = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_FB_DIV;
	wire wr_cfg = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_IN_CFG;
	wire wr_per = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_NOM_PER;
	wire wr_mode = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_LOOP_MODE;
	wire wr_lck = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_LOCK_CFG;
	wire wr_thr = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_FREQ_THR;
	wire wr_clo = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_CLAMP_LO;
	wire wr_chi = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_CLAMP_HI;
	wire wr_hl = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_HIST_LEN;
	wire wr_stab = wr_pend_ff && idx_ff == loop_supervisor_pkg::IDX_STAB_PER;
	// Feedback divider below four is raised to four.
	wire [7:0] fb_wval = (hwdata_i[7:0] < loop_supervisor_pkg::FB_DIV_MIN) ?
		loop_supervisor_pkg::FB_DIV_MIN : hwdata_i[7:0];

	// Address phase capture; writes take no wait state, reads take one.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			idx_ff <= 12'h000;
		end else begin
			if (hready_i) begin
				wr_pend_ff <= addr_take && hwrite_i;
				rd_pend_ff <= addr_take && !hwrite_i;
				idx_ff <= addr_idx;
			end
		end
	end

	// Register writes in the data phase.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			fb_div_ff <= loop_supervisor_pkg::FB_DIV_RST;
			in_cfg_ff <= 8'h00;
			nom_per_ff <= 24'h000000;
			mode_ff <= 8'h00;
			fill_ff <= loop_supervisor_pkg::FILL_RST;
			drain_ff <= loop_supervisor_pkg::DRAIN_RST;
			freq_thr_ff <= 24'h000000;
			clamp_lo_ff <= 30'h00000000;
			clamp_hi_ff <= 30'h3FFFFFFF;
			hist_len_ff <= '1;
			stab_per_ff <= 24'h000000;
		end else begin
			if (wr_fb) fb_div_ff <= fb_wval;
			if (wr_cfg) in_cfg_ff <= hwdata_i[7:0];
			if (wr_per) nom_per_ff <= hwdata_i[23:0];
			if (wr_mode) mode_ff <= hwdata_i[7:0];
			if (wr_lck) begin
				fill_ff <= hwdata_i[7:0];
				drain_ff <= hwdata_i[15:8];
			end
			if (wr_thr) freq_thr_ff <= hwdata_i[23:0];
			if (wr_clo) clamp_lo_ff <= hwdata_i[29:0];
			if (wr_chi) clamp_hi_ff <= hwdata_i[29:0];
			if (wr_hl) hist_len_ff <= hwdata_i[HIST_W-1:0];
			if (wr_stab) stab_per_ff <= hwdata_i[23:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Loop state machine.

	loop_supervisor_pkg::loop_state_t state_ff;
	loop_supervisor_pkg::loop_state_t nxt_state;
	logic ref_sel_ff;
	logic [29:0] avg_ff;
	logic avg_ok_ff;

	wire user_hold = mode_ff[loop_supervisor_pkg::MODE_USER_HOLD];
	wire user_free = mode_ff[loop_supervisor_pkg::MODE_FREE_RUN];
	wire ref_ok = ref_valid_i[ref_sel_i];
	wire ref_change = ref_sel_i != ref_sel_ff;

	// Next loop state.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			loop_supervisor_pkg::ST_FREE: begin
				if (ref_ok && !user_free && !user_hold) begin
					nxt_state = loop_supervisor_pkg::ST_LOCKED;
				end
			end
			loop_supervisor_pkg::ST_LOCKED: begin
				if (user_free) begin
					nxt_state = loop_supervisor_pkg::ST_FREE;
				end else if (!ref_ok || user_hold) begin
					nxt_state = loop_supervisor_pkg::ST_HOLD;
				end else if (ref_change) begin
					nxt_state = loop_supervisor_pkg::ST_SWITCH;
				end
			end
			loop_supervisor_pkg::ST_SWITCH: begin
				// One cycle of holdover, then straight back to closed loop.
				nxt_state = loop_supervisor_pkg::ST_LOCKED;
			end
			loop_supervisor_pkg::ST_HOLD: begin
				if (user_free) begin
					nxt_state = loop_supervisor_pkg::ST_FREE;
				end else if (ref_ok && !user_hold) begin
					nxt_state = loop_supervisor_pkg::ST_LOCKED;
				end
			end
			default: nxt_state = loop_supervisor_pkg::ST_FREE;
		endcase
	end

	wire enter_closed = nxt_state == loop_supervisor_pkg::ST_LOCKED &&
		state_ff != loop_supervisor_pkg::ST_LOCKED;
	wire closed = state_ff == loop_supervisor_pkg::ST_LOCKED;
	wire switching = state_ff == loop_supervisor_pkg::ST_SWITCH;

	// State register and profile load strobe.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_ff <= loop_supervisor_pkg::ST_FREE;
			loop_state_o <= loop_supervisor_pkg::ST_FREE;
			ref_sel_ff <= 1'b0;
			profile_load_o <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			loop_state_o <= nxt_state;
			ref_sel_ff <= ref_sel_i;
			profile_load_o <= enter_closed;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frequency lock detector.

	logic signed [12:0] acc_ff;
	logic signed [13:0] acc_sum;

	wire [24:0] diff_mag = period_i.diff_ps[24] ?
		25'(-period_i.diff_ps) : 25'(period_i.diff_ps);
	wire do_fill = diff_mag <= {1'b0, freq_thr_ff};
	wire [12:0] step = do_fill ? {5'h00, fill_ff} : {5'h00, drain_ff};

	// Saturating accumulate of one bucket.
	always_comb begin
		if (do_fill) begin
			acc_sum = 14'(acc_ff) + 14'(signed'(step));
		end else begin
			acc_sum = 14'(acc_ff) - 14'(signed'(step));
		end
	end
	wire signed [12:0] acc_sat =
		(acc_sum > 14'(loop_supervisor_pkg::ACC_MAX)) ?
		loop_supervisor_pkg::ACC_MAX :
		(acc_sum < 14'(loop_supervisor_pkg::ACC_MIN)) ?
		loop_supervisor_pkg::ACC_MIN : acc_sum[12:0];

	// Accumulator and hysteretic lock flag.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			acc_ff <= loop_supervisor_pkg::ACC_MIN;
			freq_lock_o <= 1'b0;
		end else if (switching) begin
			acc_ff <= acc_ff;
		end else if (!closed) begin
			acc_ff <= loop_supervisor_pkg::ACC_MIN;
			freq_lock_o <= 1'b0;
		end else if (period_i.valid) begin
			acc_ff <= acc_sat;
			if (acc_sat > loop_supervisor_pkg::ACC_HI) begin
				freq_lock_o <= 1'b1;
			end else if (acc_sat < loop_supervisor_pkg::ACC_LO) begin
				freq_lock_o <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tuning word clamp and history.

	logic [29:0] clamped;
	logic [37:0] hist_sum_ff;
	logic [HIST_W-1:0] hist_cnt_ff;

	// Limit a tuning word to the programmed range.
	function automatic logic [29:0] clamp_word(input logic [29:0] w,
		input logic [29:0] lo, input logic [29:0] hi);
		if (w < lo) return lo;
		if (w > hi) return hi;
		return w;
	endfunction

	assign clamped = clamp_word(tuning_i.word, clamp_lo_ff, clamp_hi_ff);
	wire hist_done = hist_cnt_ff >= hist_len_ff;
	wire [37:0] hist_next = hist_sum_ff + 38'(clamped);

	// Running sum over hist_len+1 samples while locked; a length cut to
	// or below the count so far ends the interval under way at its next sample.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hist_sum_ff <= 38'h0000000000;
			hist_cnt_ff <= '0;
			avg_ff <= 30'h00000000;
			avg_ok_ff <= 1'b0;
		end else if (closed && tuning_i.valid) begin
			if (hist_done) begin
				avg_ff <= 30'(hist_next / (38'(hist_len_ff) + 38'h1));
				avg_ok_ff <= 1'b1;
				hist_sum_ff <= 38'h0000000000;
				hist_cnt_ff <= '0;
			end else begin
				hist_sum_ff <= hist_next;
				hist_cnt_ff <= hist_cnt_ff + 1'b1;
			end
		end
	end

	// Output word: live clamped word when closed, else held average.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tuning_o <= 30'h00000000;
		end else if (closed && tuning_i.valid) begin
			tuning_o <= clamped;
		end else if (!closed && avg_ok_ff) begin
			tuning_o <= clamp_word(avg_ff, clamp_lo_ff, clamp_hi_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System clock multiplier configuration and stability timer.

	logic [15:0] edge_s1_ff;
	logic [15:0] edge_s2_ff;
	logic [4:0] tick_ff;
	logic [23:0] stab_cnt_ff;

	// Input divider code to one-hot ratio 1, 2, 4, 8.
	wire [3:0] in_div = 4'h1 << in_cfg_ff[5:4];
	wire sys_locked = edge_s2_ff <= 16'(SYS_LOCK_PS);
	wire tick = tick_ff == 5'(loop_supervisor_pkg::TICK_CYC - 1);

	// Configuration outputs and edge-difference synchroniser.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sys_fb_div_o <= loop_supervisor_pkg::FB_DIV_RST;
			sys_in_div_o <= 4'h1;
			sys_pdiv_o <= 2'h0;
			sys_dbl_o <= 1'b0;
			edge_s1_ff <= 16'hFFFF;
			edge_s2_ff <= 16'hFFFF;
		end else begin
			sys_fb_div_o <= fb_div_ff;
			sys_in_div_o <= in_div;
			sys_pdiv_o <= in_cfg_ff[loop_supervisor_pkg::IN_PDIV_LO +: 2];
			sys_dbl_o <= in_cfg_ff[loop_supervisor_pkg::IN_DBL_BIT];
			edge_s1_ff <= sys_edge_diff_ps_i;
			edge_s2_ff <= edge_s1_ff;
		end
	end

	// Stability timer counting microsecond ticks.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tick_ff <= 5'h00;
			stab_cnt_ff <= 24'h000000;
			sys_stable_o <= 1'b0;
		end else if (!sys_locked) begin
			tick_ff <= 5'h00;
			stab_cnt_ff <= 24'h000000;
			sys_stable_o <= 1'b0;
		end else if (stab_cnt_ff >= stab_per_ff) begin
			sys_stable_o <= 1'b1;
		end else begin
			tick_ff <= tick ? 5'h00 : tick_ff + 5'h01;
			if (tick) stab_cnt_ff <= stab_cnt_ff + 24'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; unmapped addresses read zero.

	always_comb begin
		case (idx_ff)
			loop_supervisor_pkg::IDX_FB_DIV: rdata = {24'h0, fb_div_ff};
			loop_supervisor_pkg::IDX_IN_CFG: rdata = {24'h0, in_cfg_ff};
			loop_supervisor_pkg::IDX_NOM_PER: rdata = {8'h0, nom_per_ff};
			loop_supervisor_pkg::IDX_LOOP_MODE: rdata = {24'h0, mode_ff};
			loop_supervisor_pkg::IDX_LOCK_CFG: rdata = {16'h0, drain_ff, fill_ff};
			loop_supervisor_pkg::IDX_FREQ_THR: rdata = {8'h0, freq_thr_ff};
			loop_supervisor_pkg::IDX_CLAMP_LO: rdata = {2'h0, clamp_lo_ff};
			loop_supervisor_pkg::IDX_CLAMP_HI: rdata = {2'h0, clamp_hi_ff};
			loop_supervisor_pkg::IDX_HIST_LEN: rdata = 32'(hist_len_ff);
			loop_supervisor_pkg::IDX_STAB_PER: rdata = {8'h0, stab_per_ff};
			loop_supervisor_pkg::IDX_STATUS: rdata = {19'h0, acc_ff[12:0]} |
				{22'h0, avg_ok_ff, state_ff, 1'b0, sys_locked,
				sys_stable_o, freq_lock_o, 1'b0} << 16;
			loop_supervisor_pkg::IDX_HIST_AVG: rdata = {2'h0, avg_ff};
			default: rdata = 32'h00000000;
		endcase
	end

	// Bus response registers; a read waits one cycle so that its word is
	// loaded from the registered address after any write that just ended.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hrdata_o <= (rd_pend_ff && !hreadyout_o) ? rdata : hrdata_o;
			hreadyout_o <= !(addr_take && !hwrite_i);
			hresp_o <= 1'b0;
		end
	end

endmodule

// ---- rtl/loop_supervisor_pkg.sv ----
// Package for the digital loop supervisor: register map, fields, constants.
// Assumes a single 25 MHz core clock and an AHB-Lite register port.
package loop_supervisor_pkg;

	// Register word indices (byte address is four times the index).
	localparam logic [11:0] IDX_FB_DIV = 12'h100;
	localparam logic [11:0] IDX_IN_CFG = 12'h101;
	localparam logic [11:0] IDX_NOM_PER = 12'h103;
	localparam logic [11:0] IDX_LOOP_MODE = 12'hA01;
	localparam logic [11:0] IDX_LOCK_CFG = 12'hA10;
	localparam logic [11:0] IDX_FREQ_THR = 12'hA11;
	localparam logic [11:0] IDX_CLAMP_LO = 12'hA12;
	localparam logic [11:0] IDX_CLAMP_HI = 12'hA13;
	localparam logic [11:0] IDX_HIST_LEN = 12'hA14;
	localparam logic [11:0] IDX_STAB_PER = 12'hA15;
	localparam logic [11:0] IDX_STATUS = 12'hA16;
	localparam logic [11:0] IDX_HIST_AVG = 12'hA17;

	// Field positions.
	localparam int IN_DBL_BIT = 0;
	localparam int IN_PDIV_LO = 1;
	localparam int MODE_USER_HOLD = 6;
	localparam int MODE_FREE_RUN = 5;

	// Reset values and feedback divider minimum.
	localparam logic [7:0] FB_DIV_RST = 8'h04;
	localparam logic [7:0] FB_DIV_MIN = 8'h04;
	localparam logic [7:0] FILL_RST = 8'h08;
	localparam logic [7:0] DRAIN_RST = 8'h08;

	// Lock accumulator bounds.
	localparam logic signed [12:0] ACC_MAX = 13'sh0800;
	localparam logic signed [12:0] ACC_MIN = -13'sh0800;
	localparam logic signed [12:0] ACC_HI = 13'sh0400;
	localparam logic signed [12:0] ACC_LO = -13'sh0400;

	// Stability timer tick: 1 us of 40 ns cycles.
	localparam int CLK_NS = 40;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;

	// Loop states, one-hot.
	typedef enum logic [3:0] {
		ST_FREE = 4'h1,
		ST_LOCKED = 4'h2,
		ST_SWITCH = 4'h4,
		ST_HOLD = 4'h8
	} loop_state_t;

	// Period-difference sample from the phase detector.
	typedef struct packed {
		logic valid;
		logic signed [24:0] diff_ps;
	} period_sample_t;

	// Tuning word sample from the loop filter.
	typedef struct packed {
		logic valid;
		logic [29:0] word;
	} tuning_sample_t;

endpackage

// ---- tb/loop_supervisor_props.sv ----
// Checker for the loop supervisor, watching its ports only.
// Assumes the bind below reaches every loop_supervisor instance.
`timescale 1ns/100ps
module loop_supervisor_props #(
	parameter int HIST_W = 8,
	parameter int SYS_LOCK_PS = 1000
) (
	// Clock, reset and bus.
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	// Loop and system clock inputs.
	input wire loop_supervisor_pkg::period_sample_t period_i,
	input wire logic [1:0] ref_valid_i,
	input wire logic [15:0] sys_edge_diff_ps_i,
	// Watched outputs.
	input wire logic freq_lock_o,
	input wire logic profile_load_o,
	input wire logic [7:0] sys_fb_div_o,
	input wire logic [3:0] sys_in_div_o,
	input wire logic [1:0] sys_pdiv_o,
	input wire logic sys_stable_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	// A write address phase aimed at one register index.
	sequence s_wr(logic [11:0] idx);
		hsel_i && hready_i && htrans_i[1] && hwrite_i &&
			haddr_i[13:2] == idx;
	endsequence
	property p_fb_wr;
		logic [7:0] d;
		s_wr(loop_supervisor_pkg::IDX_FB_DIV) ##1 (1, d = hwdata_i[7:0])
			|=> ##1 sys_fb_div_o == (d < 8'h04 ? 8'h04 : d);
	endproperty
	a_fb_wr: assert property (p_fb_wr)
		else $error("feedback divider not applied");
	property p_in_wr;
		logic [1:0] c;
		s_wr(loop_supervisor_pkg::IDX_IN_CFG) ##1 (1, c = hwdata_i[5:4])
			|=> ##1 sys_in_div_o == 4'h1 << c;
	endproperty
	a_in_wr: assert property (p_in_wr)
		else $error("input divider not applied");
	property p_pdiv_wr;
		logic [1:0] c;
		s_wr(loop_supervisor_pkg::IDX_IN_CFG) ##1 (1, c = hwdata_i[2:1])
			|=> ##1 sys_pdiv_o == c;
	endproperty
	a_pdiv_wr: assert property (p_pdiv_wr)
		else $error("prescale field not applied");
	property p_in_1hot;
		sys_in_div_o inside {4'h1, 4'h2, 4'h4, 4'h8};
	endproperty
	a_in_1hot: assert property (p_in_1hot)
		else $error("input divider not one of four ratios");
	property p_lock_rise;
		$rose(freq_lock_o) |-> $past(period_i.valid);
	endproperty
	a_lock_rise: assert property (p_lock_rise)
		else $error("lock rose without a sample");
	property p_stab_lost;
		(sys_edge_diff_ps_i > SYS_LOCK_PS) [*6] |=> !sys_stable_o;
	endproperty
	a_stab_lost: assert property (p_stab_lost)
		else $error("stable kept while condition lost");
	property p_hold_unlock;
		(ref_valid_i == 2'h0) [*4] |=> !freq_lock_o;
	endproperty
	a_hold_unlock: assert property (p_hold_unlock)
		else $error("lock shown without any reference");
	property p_pulse;
		profile_load_o |=> !profile_load_o;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("profile load longer than one cycle");
endmodule
bind loop_supervisor loop_supervisor_props #(.HIST_W(HIST_W),
	.SYS_LOCK_PS(SYS_LOCK_PS)) props_i (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .period_i(period_i), .ref_valid_i(ref_valid_i),
	.sys_edge_diff_ps_i(sys_edge_diff_ps_i), .freq_lock_o(freq_lock_o),
	.profile_load_o(profile_load_o), .sys_fb_div_o(sys_fb_div_o),
	.sys_in_div_o(sys_in_div_o), .sys_pdiv_o(sys_pdiv_o),
	.sys_stable_o(sys_stable_o));

// ---- tb/ref_side_model.sv ----
// Model of the references, loop filter and system clock oscillator.
// Assumes the supervisor's clock; the bench sets the levels it shows.
`timescale 1ns/100ps
module ref_side_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench controls.
	input wire logic in_tol_i,
	input wire logic [1:0] refs_on_i,
	input wire logic sys_ok_i,
	input wire logic [29:0] word_i,
	// Samples and levels toward the supervisor.
	output loop_supervisor_pkg::period_sample_t period_o,
	output loop_supervisor_pkg::tuning_sample_t tuning_o,
	output logic [1:0] ref_valid_o,
	output logic [15:0] sys_diff_o
);
	logic [3:0] cyc_ff;
	wire logic hit = cyc_ff[2:0] == 3'h7;
	wire logic signed [24:0] mag = in_tol_i ? 25'sh28 : 25'sh1388;
	// One sample per eight cycles, sign alternating; lines scramble between.
	always_ff @(posedge clk_i) begin
		cyc_ff <= rst_i ? 4'h0 : cyc_ff + 4'h1;
		period_o.valid <= hit && !rst_i;
		tuning_o.valid <= hit && !rst_i;
		period_o.diff_ps <= hit ? (cyc_ff[3] ? -mag : mag) : ~period_o.diff_ps;
		tuning_o.word <= hit ? word_i : ~tuning_o.word;
		ref_valid_o <= refs_on_i;
		sys_diff_o <= sys_ok_i ? 16'h00C8 : 16'h4E20;
	end
endmodule

// ---- tb/loop_supervisor_bench.sv ----
// Self-checking bench for the loop supervisor.
// Assumes the reference side model and the bound checker are compiled.
`timescale 1ns/100ps
module loop_supervisor_bench;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic ref_sel_i = 1'b0;
	logic in_tol = 1'b1;
	logic [1:0] refs_on = 2'h3;
	logic sys_ok = 1'b0;
	logic [29:0] word = 30'h2000;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	loop_supervisor_pkg::period_sample_t period_i;
	loop_supervisor_pkg::tuning_sample_t tuning_i;
	logic [1:0] ref_valid_i;
	logic [15:0] sys_diff;
	logic [29:0] tuning_o;
	logic freq_lock_o;
	logic profile_load_o;
	logic [7:0] sys_fb_div_o;
	logic [3:0] sys_in_div_o;
	logic [1:0] sys_pdiv_o;
	logic sys_dbl_o;
	logic sys_stable_o;
	logic [3:0] loop_state_o;
	logic hresp_o;
	logic [31:0] r;
	int n;
	int miscompares = 0;
	int n_tests = 0;
	////////////////////////////////////////////////////////////////////////
	// Design, far side and a 25 MHz clock.
	loop_supervisor loop_supervisor_i (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.period_i(period_i), .tuning_i(tuning_i),
		.ref_valid_i(ref_valid_i),
		.ref_sel_i(ref_sel_i), .sys_edge_diff_ps_i(sys_diff),
		.tuning_o(tuning_o), .freq_lock_o(freq_lock_o),
		.loop_state_o(loop_state_o),
		.profile_load_o(profile_load_o), .sys_fb_div_o(sys_fb_div_o),
		.sys_in_div_o(sys_in_div_o), .sys_pdiv_o(sys_pdiv_o),
		.sys_dbl_o(sys_dbl_o), .sys_stable_o(sys_stable_o));
	ref_side_model ref_side_model_i (.clk_i(core_clk_i), .rst_i(rst_i),
		.in_tol_i(in_tol), .refs_on_i(refs_on), .sys_ok_i(sys_ok),
		.word_i(word), .period_o(period_i), .tuning_o(tuning_i),
		.ref_valid_o(ref_valid_i), .sys_diff_o(sys_diff));
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	// Verdict, comparison and waiting helpers.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return freq_lock_o;
			1: return sys_stable_o;
			default: return profile_load_o;
		endcase
	endfunction
	// Bounded wait for an output level; running out ends the run.
	task automatic await(input int w, input logic v, input int lim);
		n = 0;
		while (pick(w) !== v && n < lim) begin
			@(posedge core_clk_i);
			n++;
		end
		chk("wait result", 32'(v), 32'(pick(w)));
		if (pick(w) !== v)
			tally_and_finish();
	endtask
	task automatic hwait;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 20);
		if (hreadyout_o !== 1'b1) begin
			chk("hready", 32'h1, 32'(hreadyout_o));
			tally_and_finish();
		end
	endtask
	// One AHB-Lite single word transfer: address phase, then data phase.
	task automatic xfer(input logic [11:0] i, input logic w, logic [31:0] d);
		hsel_i <= 1'b1;
		haddr_i <= {18'h0, i, 2'h0};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		hwait();
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		hwait();
		r = hrdata_o;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Multiplier settings, clamped divider, unmapped access.
	task automatic t_config;
		xfer(loop_supervisor_pkg::IDX_NOM_PER, 1'b1, 32'h28);
		xfer(loop_supervisor_pkg::IDX_NOM_PER, 1'b0, 32'h0);
		chk("period read", 32'h28, r);
		xfer(loop_supervisor_pkg::IDX_FB_DIV, 1'b1, 32'h20);
		xfer(loop_supervisor_pkg::IDX_FB_DIV, 1'b0, 32'h0);
		chk("fb read", 32'h20, r);
		xfer(loop_supervisor_pkg::IDX_FB_DIV, 1'b1, 32'h02);
		xfer(12'h3FF, 1'b1, 32'hFFFF_FFFF);
		chk("fb low", 32'h04, 32'(sys_fb_div_o));
		xfer(12'h3FF, 1'b0, 32'h0);
		chk("unmapped", 32'h0, r);
		chk("hresp", 32'h0, 32'(hresp_o));
		xfer(loop_supervisor_pkg::IDX_FB_DIV, 1'b1, 32'hFF);
		for (int c = 0; c < 4; c++) begin
			// Doubler on odd codes: input taken below 75 MHz.
			xfer(loop_supervisor_pkg::IDX_IN_CFG, 1'b1,
				32'(c) << 4 | 32'(c) << 1 | 32'(c & 1));
			// Outputs copy the register one edge after it lands.
			repeat (2) @(posedge core_clk_i);
			chk("in div", 32'h1 << c, 32'(sys_in_div_o));
			chk("pdiv", 32'(c), 32'(sys_pdiv_o));
			chk("dbl", 32'(c & 1), 32'(sys_dbl_o));
		end
		chk("fb high", 32'hFF, 32'(sys_fb_div_o));
		// Halved feedback value for the doubled input.
		xfer(loop_supervisor_pkg::IDX_FB_DIV, 1'b1, 32'h10);
	endtask
	// Stability timer: unstable start, broken run, full run, zero period.
	task automatic t_stab;
		xfer(loop_supervisor_pkg::IDX_STAB_PER, 1'b1, 32'h4);
		repeat (10) @(posedge core_clk_i);
		chk("stable early", 32'h0, 32'(sys_stable_o));
		sys_ok <= 1'b1;
		repeat (40) @(posedge core_clk_i);
		sys_ok <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		sys_ok <= 1'b1;
		repeat (60) @(posedge core_clk_i);
		chk("stable restart", 32'h0, 32'(sys_stable_o));
		await(1, 1'b1, 100);
		// All four ticks of the period must pass before stable shows.
		chk("stable span", 32'h1,
			32'(n + 60 >= 4 * loop_supervisor_pkg::TICK_CYC));
		sys_ok <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		chk("stable lost", 32'h0, 32'(sys_stable_o));
		xfer(loop_supervisor_pkg::IDX_STAB_PER, 1'b1, 32'h0);
		sys_ok <= 1'b1;
		await(1, 1'b1, 10);
	endtask
	// Frequency lock fill, drain and a switchover while locked.
	task automatic t_lock;
		xfer(loop_supervisor_pkg::IDX_FREQ_THR, 1'b1, 32'h64);
		xfer(loop_supervisor_pkg::IDX_LOCK_CFG, 1'b1, 32'hFFFF);
		refs_on <= 2'h0;
		repeat (8) @(posedge core_clk_i);
		refs_on <= 2'h3;
		await(0, 1'b1, 400);
		chk("fill span", 32'h1, 32'(n >= 90));
		in_tol <= 1'b0;
		// Nine drains of 255, eight cycles apart, take 1267 below -1024.
		await(0, 1'b0, 400);
		chk("drain span", 32'h1, 32'(n >= 64));
		in_tol <= 1'b1;
		await(0, 1'b1, 400);
		ref_sel_i <= 1'b1;
		await(2, 1'b1, 10);
		repeat (3) @(posedge core_clk_i);
		chk("lock kept", 32'h1, 32'(freq_lock_o));
	endtask
	// Clamp limits, history average, user holdover and recovery.
	task automatic t_clamp_hold;
		xfer(loop_supervisor_pkg::IDX_CLAMP_LO, 1'b1, 32'h0);
		xfer(loop_supervisor_pkg::IDX_CLAMP_HI, 1'b1, 32'h1000);
		repeat (20) @(posedge core_clk_i);
		chk("clamp hi", 32'h1000, 32'(tuning_o));
		xfer(loop_supervisor_pkg::IDX_CLAMP_LO, 1'b1, 32'h800);
		xfer(loop_supervisor_pkg::IDX_CLAMP_HI, 1'b1, 32'h3FFF_FFFF);
		word <= 30'h100;
		repeat (20) @(posedge core_clk_i);
		chk("clamp lo", 32'h800, 32'(tuning_o));
		xfer(loop_supervisor_pkg::IDX_HIST_LEN, 1'b1, 32'h3);
		word <= 30'h900;
		repeat (80) @(posedge core_clk_i);
		xfer(loop_supervisor_pkg::IDX_LOOP_MODE, 1'b1, 32'h40);
		await(0, 1'b0, 5);
		word <= 30'hA00;
		repeat (40) @(posedge core_clk_i);
		chk("hold word", 32'h900, 32'(tuning_o));
		n = 0;
		repeat (40) begin
			@(posedge core_clk_i);
			n += int'(profile_load_o === 1'b1);
		end
		chk("no recovery", 32'h0, 32'(n));
		chk("hold state", 32'h8, 32'(loop_state_o));
		chk("hold steady", 32'h900, 32'(tuning_o));
		xfer(loop_supervisor_pkg::IDX_LOOP_MODE, 1'b1, 32'h0);
		await(2, 1'b1, 10);
		chk("closed state", 32'h2, 32'(loop_state_o));
	endtask
	////////////////////////////////////////////////////////////////////////
	// Reset for six cycles, then the scenarios in turn.
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		t_config();
		t_stab();
		t_lock();
		t_clamp_hold();
		tally_and_finish();
	end
endmodule
